// *** hw/evr_matrix.sv ***
// Event channel routing matrix: generator select per channel, channel select per user.
// Assumes an AHB-Lite master on hclk and generators that hold events for at least
// one hclk period on the synchronous path.
//
// Operation
// - eight channel generator registers, reset zero
// - zero select keeps channel off
// - generators limited per channel
// - tap codes follow channel parity
// - pin, serial clock, capture code decoding
// - twenty-four user registers, reset zero
// - many users may share one channel
// - user index equals user identifier
// - zero disconnects, n picks channel n-1
// - user subchannel class by identifier
// - async and sync subchannels per channel
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "evr_map.svh"

module evr_matrix #(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Event generators
	input wire evr_pkg::evr_gen_t gen_i,
	// Channel subchannels
	output logic [`EVR_NUM_CH-1:0] ch_async_o,
	output logic [`EVR_NUM_CH-1:0] ch_sync_o,
	// Event users
	output logic [`EVR_NUM_USER-1:0] user_async_o,
	output logic [`EVR_NUM_USER-1:0] user_sync_o
);
	import evr_pkg::*;

	// Decode needs the bits above the register window
	if (ADDR_W < 9) begin : g_bad_addr_w
		$error("ADDR_W must be at least 9");
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [7:0] ch_sel_q [`EVR_NUM_CH];
	logic [7:0] user_sel_q [`EVR_NUM_USER];
	logic wr_q;
	logic [5:0] widx_q;
	logic [31:0] hrdata_q;
	logic [`EVR_NUM_CH-1:0] ch_async_q;
	logic [`EVR_NUM_CH-1:0] ch_sync_q;
	logic [`EVR_NUM_CH-1:0] sync1_q;
	logic [`EVR_NUM_CH-1:0] sync2_q;
	logic [`EVR_NUM_USER-1:0] user_async_q;
	logic [`EVR_NUM_USER-1:0] user_sync_q;
	evr_route_t route_w [`EVR_NUM_CH];
	logic [`EVR_NUM_CH-1:0] ch_async_d;
	logic [`EVR_NUM_CH-1:0] ch_sync_d;

	// Bus decode
	wire accept = hsel && htrans[1] && hready;
	wire [5:0] aidx = haddr[7:2];
	wire upper_zero = (haddr[ADDR_W-1:8] == '0);
	wire hit_ch = upper_zero && (aidx[5:3] == 3'(`EVR_CH_IDX >> 3));
	wire [5:0] uoff = aidx - `EVR_USER_IDX;
	wire hit_user = upper_zero && (aidx >= `EVR_USER_IDX) && (uoff < `EVR_USER_SPAN);
	wire [7:0] rd_reg = hit_ch ? ch_sel_q[aidx[2:0]] :
		hit_user ? user_sel_q[uoff[4:0]] : 8'h00;
	// Pending write to the same register is forwarded, else a back-to-back read is stale
	wire fwd = wr_q && upper_zero && (widx_q == aidx);
	wire [7:0] rd_byte = fwd ? hwdata[7:0] : rd_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			widx_q <= 6'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_q <= accept && hwrite && (hit_ch || hit_user);
			widx_q <= aidx;
			if (accept && !hwrite) begin
				hrdata_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// Route one generator code onto channel ch
	function automatic evr_route_t evr_route(input logic [7:0] code, input int ch,
		input evr_gen_t g);
		evr_route_t r;
		logic [2:0] tix;
		logic [2:0] pidx;
		logic port_ok;
		r.evt = 1'b0;
		r.is_async = 1'b1;
		tix = {ch[0], code[1:0]};
		port_ok = (ch < `EVR_NUM_PORT_CH);
		pidx = port_ok ? {ch[2:1], 1'b0} : 3'h0;
		case (code) inside
			`EVR_GEN_DEBUG: begin
				r.evt = (ch == `EVR_CH_SOLE) && g.debug_evt;
				r.is_async = 1'b0;
			end
			`EVR_GEN_RTC_OVERFLOW_EVENT: begin
				r.evt = (ch == `EVR_CH_SOLE) && g.rtc_overflow_event;
			end
			`EVR_GEN_RTC_CMP: begin
				r.evt = g.rtc_cmp;
			end
			[`EVR_GEN_TAP_LO:`EVR_GEN_TAP_HI]: begin
				r.evt = g.rtc_tap[tix];
			end
			[`EVR_GEN_LUT_LO:`EVR_GEN_LUT_HI]: begin
				r.evt = g.lut_out[code[1:0]];
			end
			`EVR_GEN_AC: begin
				r.evt = g.ac_out;
			end
			`EVR_GEN_ADC: begin
				r.evt = g.adc_resrdy;
				r.is_async = 1'b0;
			end
			[`EVR_GEN_PORT0_LO:`EVR_GEN_PORT0_HI]: begin
				r.evt = port_ok && g.port_pin[pidx][code[2:0]];
			end
			[`EVR_GEN_PORT1_LO:`EVR_GEN_PORT1_HI]: begin
				r.evt = port_ok && g.port_pin[pidx + 3'h1][code[2:0]];
			end
			[`EVR_GEN_USART_LO:`EVR_GEN_USART_HI]: begin
				r.evt = g.usart_xck[code[2:0]];
				r.is_async = 1'b0;
			end
			`EVR_GEN_SPI: begin
				r.evt = g.spi_sck;
				r.is_async = 1'b0;
			end
			`EVR_GEN_TCA_OVF: begin
				r.evt = g.tca_ovf;
				r.is_async = 1'b0;
			end
			`EVR_GEN_TCA_HUNF: begin
				r.evt = g.tca_hunf;
				r.is_async = 1'b0;
			end
			[`EVR_GEN_TCA_CMP_LO:`EVR_GEN_TCA_CMP_HI]: begin
				r.evt = g.tca_cmp[code[1:0]];
				r.is_async = 1'b0;
			end
			[`EVR_GEN_TCB_LO:`EVR_GEN_TCB_HI]: begin
				r.evt = !code[0] && g.tcb_capt[code[3:1]];
				r.is_async = 1'b0;
			end
			default: begin
				r.evt = 1'b0;
			end
		endcase
		return r;
	endfunction

	genvar n;
	generate
		for (n = 0; n < `EVR_NUM_CH; n++) begin : g_ch
			wire wen = wr_q && (widx_q == `EVR_CH_IDX + 6'(n));
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ch_sel_q[n] <= `EVR_SEL_RST;
				end else if (wen) begin
					ch_sel_q[n] <= hwdata[7:0];
				end
			end
			assign route_w[n] = evr_route(ch_sel_q[n], n, gen_i);
			assign ch_async_d[n] = route_w[n].evt;
			assign ch_sync_d[n] = route_w[n].is_async ? sync2_q[n] : route_w[n].evt;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ch_async_q[n] <= 1'b0;
					ch_sync_q[n] <= 1'b0;
					sync1_q[n] <= 1'b0;
					sync2_q[n] <= 1'b0;
				end else begin
					ch_async_q[n] <= ch_async_d[n];
					ch_sync_q[n] <= ch_sync_d[n];
					sync1_q[n] <= route_w[n].evt;
					sync2_q[n] <= sync1_q[n];
				end
			end
		end
	endgenerate

	assign ch_async_o = ch_async_q;
	assign ch_sync_o = ch_sync_q;

	genvar u;
	generate
		for (u = 0; u < `EVR_NUM_USER; u++) begin : g_user
			localparam bit TAKES_ASYNC = (u <= `EVR_USER_ASYNC_LAST) ||
				(u >= `EVR_USER_BOTH_FIRST);
			localparam bit TAKES_SYNC = (u >= `EVR_USER_SYNC_FIRST);
			wire wen = wr_q && (widx_q == `EVR_USER_IDX + 6'(u));
			wire [7:0] usel = user_sel_q[u];
			// zero off, n is channel n-1
			wire linked = (usel != 8'h00) && (usel <= 8'(`EVR_NUM_CH));
			wire [2:0] cidx = 3'(usel - 8'h01);
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					user_sel_q[u] <= `EVR_SEL_RST;
				end else if (wen) begin
					user_sel_q[u] <= hwdata[7:0];
				end
			end
			// shared channel fan-out and subchannel by class
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					user_async_q[u] <= 1'b0;
					user_sync_q[u] <= 1'b0;
				end else begin
					user_async_q[u] <= TAKES_ASYNC && linked && ch_async_d[cidx];
					user_sync_q[u] <= TAKES_SYNC && linked && ch_sync_d[cidx];
				end
			end
		end
	endgenerate

	assign user_async_o = user_async_q;
	assign user_sync_o = user_sync_q;

	// Checks
	sequence s_cmp_held;
		(ch_sel_q[2] == `EVR_GEN_RTC_CMP) [*4];
	endsequence

	AST_CH_WRITE: assert property (wr_q && widx_q == `EVR_CH_IDX |=>
		ch_sel_q[0] == $past(hwdata[7:0]))
		else $error("channel select write lost");
	AST_CH_OFF: assert property (ch_sel_q[3] == `EVR_GEN_OFF |=> !ch_async_q[3])
		else $error("off channel carries an event");
	AST_CH1_ONLY: assert property (ch_sel_q[0] == `EVR_GEN_DEBUG |=> !ch_async_q[0])
		else $error("debug event routed off its channel");
	AST_TAP_ODD: assert property (ch_sel_q[1] == `EVR_GEN_TAP_LO |=>
		ch_async_q[1] == $past(gen_i.rtc_tap[4]))
		else $error("odd channel took wrong tap");
	AST_PIN_NONE: assert property (ch_sel_q[6] inside {[`EVR_GEN_PORT0_LO:`EVR_GEN_PORT1_HI]}
		|=> !ch_async_q[6])
		else $error("pin event on channel without port");
	AST_USER_WRITE: assert property (wr_q && widx_q == `EVR_USER_IDX + 6'h17 |=>
		user_sel_q[23] == $past(hwdata[7:0]))
		else $error("user select write lost");
	AST_FANOUT: assert property (user_sel_q[9] == 8'h03 && user_sel_q[20] == 8'h03
		|=> user_async_q[9] == ch_async_q[2] && user_async_q[20] == ch_async_q[2])
		else $error("shared channel not fanned out");
	AST_USER_OFF: assert property (user_sel_q[8] == `EVR_SEL_RST |=> !user_async_q[8])
		else $error("disconnected user sees an event");
	AST_SYNC_ONLY: assert property (!user_async_q[15] && !user_sync_q[14])
		else $error("user on wrong subchannel");
	AST_SYNC_DELAY: assert property (s_cmp_held |->
		ch_sync_q[2] == $past(gen_i.rtc_cmp, 3))
		else $error("async source not delayed two cycles");
	AST_BAD_CODE: assert property (ch_sel_q[5] == 8'h02 |=> !ch_async_q[5])
		else $error("unlisted code drives channel");

endmodule
`default_nettype wire

// *** hw/evr_map.svh ***
// Register map, generator codes and user classes of the event routing matrix.
// Assumes inclusion by bare name from the design files.
`ifndef EVR_MAP_SVH
`define EVR_MAP_SVH

// Register indexes; byte address is four times the index
`define EVR_CH_IDX 6'h10
`define EVR_USER_IDX 6'h20
`define EVR_USER_SPAN 6'h18
`define EVR_SEL_RST 8'h00

// Geometry
`define EVR_NUM_CH 8
`define EVR_NUM_USER 24
`define EVR_NUM_PORT_CH 6

// Generator codes
`define EVR_GEN_OFF 8'h00
`define EVR_GEN_DEBUG 8'h01
`define EVR_GEN_RTC_OVERFLOW_EVENT 8'h06
`define EVR_GEN_RTC_CMP 8'h07
`define EVR_GEN_TAP_LO 8'h08
`define EVR_GEN_TAP_HI 8'h0b
`define EVR_GEN_LUT_LO 8'h10
`define EVR_GEN_LUT_HI 8'h13
`define EVR_GEN_AC 8'h20
`define EVR_GEN_ADC 8'h24
`define EVR_GEN_PORT0_LO 8'h40
`define EVR_GEN_PORT0_HI 8'h47
`define EVR_GEN_PORT1_LO 8'h48
`define EVR_GEN_PORT1_HI 8'h4f
`define EVR_GEN_USART_LO 8'h60
`define EVR_GEN_USART_HI 8'h67
`define EVR_GEN_SPI 8'h68
`define EVR_GEN_TCA_OVF 8'h80
`define EVR_GEN_TCA_HUNF 8'h81
`define EVR_GEN_TCA_CMP_LO 8'h84
`define EVR_GEN_TCA_CMP_HI 8'h86
`define EVR_GEN_TCB_LO 8'ha0
`define EVR_GEN_TCB_HI 8'hae

// The only channel that takes debug and overflow events
`define EVR_CH_SOLE 1

// User classes by identifier
`define EVR_USER_ASYNC_LAST 14
`define EVR_USER_SYNC_FIRST 15
`define EVR_USER_BOTH_FIRST 20

`endif

// *** hw/evr_pkg.sv ***
// Types shared by the event routing matrix and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package evr_pkg;

	// Event generator outputs, all one bit per source
	typedef struct packed {
		logic debug_evt;
		logic rtc_overflow_event;
		logic rtc_cmp;
		logic [7:0] rtc_tap;
		logic [3:0] lut_out;
		logic ac_out;
		logic adc_resrdy;
		logic [5:0][7:0] port_pin;
		logic [7:0] usart_xck;
		logic spi_sck;
		logic tca_ovf;
		logic tca_hunf;
		logic [2:0] tca_cmp;
		logic [7:0] tcb_capt;
	} evr_gen_t;

	// Routed event of one generator select
	typedef struct packed {
		logic is_async;
		logic evt;
	} evr_route_t;

endpackage

// *** sim/evr_gen_model.sv ***
// Generator side model: one-cycle event pulses on command.
// Assumes commands change just after rising edges of hclk.
`timescale 1ns/100ps
`default_nettype none
module evr_gen_model (
	// Clock
	input wire logic hclk,
	// Command
	input wire logic fire,
	input wire evr_pkg::evr_gen_t pat,
	// Generator outputs
	output var evr_pkg::evr_gen_t gen
);
	import evr_pkg::*;
	// Events last one cycle and read low in between
	always_ff @(posedge hclk) begin
		gen <= fire ? pat : '0;
	end
endmodule
`default_nettype wire

// *** sim/event_channel_routing_matrix_tb.sv ***
// Bench of the event routing matrix: register access and event routing.
// Assumes the generator model and the design files under hw/.
`timescale 1ns/100ps
`default_nettype none
module event_channel_routing_matrix_tb;
	import evr_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic hready;
	wire logic hresp;
	wire logic [31:0] hrdata;
	logic fire = 1'b0;
	evr_gen_t pat = '0;
	evr_gen_t p;
	wire evr_gen_t gen;
	wire logic [7:0] ch_a;
	wire logic [7:0] ch_s;
	wire logic [23:0] us_a;
	wire logic [23:0] us_s;
	int num_errors = 0;
	int comparisons = 0;
	always #10 hclk = ~hclk;
	evr_gen_model i_evr_gen_model (.hclk(hclk), .fire(fire), .pat(pat), .gen(gen));
	evr_matrix i_evr_matrix (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .gen_i(gen), .ch_async_o(ch_a),
		.ch_sync_o(ch_s), .user_async_o(us_a), .user_sync_o(us_s));
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic waitrdy;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask
	task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		waitrdy();
		htrans <= 2'h0;
		hwdata <= d;
		waitrdy();
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, idx, d, q);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] e, input string nm);
		logic [31:0] q;
		acc(1'b0, idx, 32'h0, q);
		chk(nm, e, q);
	endtask
	// Pulse at one edge, then stop in the first output cycle
	task automatic pulse(input evr_gen_t v);
		@(posedge hclk);
		pat <= v;
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		@(posedge hclk);
		@(negedge hclk);
	endtask
	// Route one code to channel ch and user ch, then watch both subchannels
	task automatic ev(input int ch, input logic [7:0] c, input evr_gen_t v, input logic e,
		input logic s);
		wr(8'h10 + ch[7:0], {24'h0, c});
		wr(8'h20 + ch[7:0], 32'(ch + 1));
		pulse(v);
		chk("ch_async", {31'h0, e}, {31'h0, ch_a[ch]});
		chk("ch_sync_early", {31'h0, e & s}, {31'h0, ch_s[ch]});
		chk("user_async", {31'h0, e}, {31'h0, us_a[ch]});
		@(negedge hclk);
		chk("ch_async_len", 32'h0, {31'h0, ch_a[ch]});
		@(negedge hclk);
		chk("ch_sync_late", {31'h0, e & ~s}, {31'h0, ch_s[ch]});
	endtask
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(8'h10 + i[7:0], 32'h0, "chan_reset");
		end
		for (int i = 0; i < 24; i++) begin
			rd(8'h20 + i[7:0], 32'h0, "user_reset");
		end
		wr(8'h17, 32'hffffffa5);
		rd(8'h17, 32'ha5, "chan_rw");
		wr(8'h37, 32'h5a);
		rd(8'h37, 32'h5a, "user_rw");
		wr(8'h18, 32'h33);
		rd(8'h18, 32'h0, "unmapped");
		$display("test registers done");
		p = '1;
		ev(0, 8'h00, p, 1'b0, 1'b0);
		ev(6, 8'h40, p, 1'b0, 1'b0);
		ev(5, 8'ha3, p, 1'b0, 1'b0);
		ev(5, 8'h02, p, 1'b0, 1'b0);
		p = '0;
		p.rtc_cmp = 1'b1;
		ev(2, 8'h07, p, 1'b1, 1'b0);
		p = '0;
		p.debug_evt = 1'b1;
		ev(0, 8'h01, p, 1'b0, 1'b0);
		ev(1, 8'h01, p, 1'b1, 1'b1);
		p = '0;
		p.rtc_overflow_event = 1'b1;
		ev(3, 8'h06, p, 1'b0, 1'b0);
		ev(1, 8'h06, p, 1'b1, 1'b0);
		for (int k = 0; k < 4; k++) begin
			p = '0;
			p.rtc_tap[k] = 1'b1;
			ev(0, 8'h08 + k[7:0], p, 1'b1, 1'b0);
			p = '0;
			p.rtc_tap[k + 4] = 1'b1;
			ev(1, 8'h08 + k[7:0], p, 1'b1, 1'b0);
		end
		p = '0;
		p.port_pin[5][2] = 1'b1;
		ev(4, 8'h4a, p, 1'b1, 1'b0);
		p = '0;
		p.usart_xck[5] = 1'b1;
		ev(3, 8'h65, p, 1'b1, 1'b1);
		p = '0;
		p.tcb_capt[3] = 1'b1;
		ev(5, 8'ha6, p, 1'b1, 1'b1);
		$display("test generators done");
		wr(8'h29, 32'h3);
		wr(8'h2f, 32'h3);
		wr(8'h34, 32'h3);
		p = '0;
		p.rtc_cmp = 1'b1;
		pulse(p);
		chk("fan_async", 32'h100204, {8'h0, us_a});
		chk("fan_sync_early", 32'h0, {8'h0, us_s});
		repeat (2) @(negedge hclk);
		chk("fan_sync", 32'h108000, {8'h0, us_s});
		$display("test fan out done");
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
